// [pkg/wdu_pkg.sv]
package wdu_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] WDU_IDX_CTRL = 6'h00;
   localparam logic [5:0] WDU_IDX_STAT = 6'h01;
   localparam logic [7:0] WDU_ADDR_CTRL = {WDU_IDX_CTRL, 2'h0};
   localparam logic [7:0] WDU_ADDR_STAT = {WDU_IDX_STAT, 2'h0};

   // Control field positions
   localparam int WDU_WIN_MSB = 7;
   localparam int WDU_WIN_LSB = 4;
   localparam int WDU_PER_MSB = 3;
   localparam int WDU_PER_LSB = 0;

   // Status field positions, and reset values of status and control
   localparam int WDU_LOCK_BIT = 7;
   localparam int WDU_BUSY_BIT = 0;
   localparam logic [7:0] WDU_STAT_RST = 8'h00;
   localparam logic [7:0] WDU_CTRL_RST = 8'h00;

   // Period codes and lengths in watchdog clock ticks
   localparam logic [3:0] WDU_CODE_OFF = 4'h0;
   localparam logic [3:0] WDU_CODE_MIN = 4'h1;
   localparam logic [3:0] WDU_CODE_MAX = 4'hB;
   localparam logic [13:0] WDU_BASE_TICKS = 14'h0008;

   // Watchdog ticks needed to carry a control write across
   localparam logic [1:0] WDU_SYNC_TICKS = 2'h2;

   // Instruction steps after the key that end the protected write window
   localparam logic [2:0] WDU_UNLOCK_INSTR = 3'h4;

   typedef enum logic [1:0] {
      WDU_OFF,
      WDU_NORMAL,
      WDU_CLOSED,
      WDU_OPEN
   } wdu_state_t;

endpackage

// [rtl/wdu_unlock.sv]
`timescale 1ns/1ps
module wdu_unlock
   import wdu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic key_written,
   input wire logic instr_step,
   input wire logic consume,
   output logic unlocked
);

   logic [2:0] budget_r;
   logic [2:0] budget_nxt;

   ////////////////////////////////////////////////////////////////////
   // Key opens a window of a few instructions; a protected write
   // closes it, so one key buys at most one protected write.
   always_comb begin
      budget_nxt = budget_r;
      if (consume) begin
         budget_nxt = 3'h0;
      end else if (instr_step && budget_r != 3'h0) begin
         budget_nxt = budget_r - 3'h1;
      end
      if (key_written) begin
         budget_nxt = WDU_UNLOCK_INSTR;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         budget_r <= 3'h0;
      end else if (pce) begin
         budget_r <= budget_nxt;
      end
   end

   assign unlocked = (budget_r != 3'h0);

endmodule

// [rtl/wdu_core.sv]
//
// Behaviour
// - Protected write needs key within four instructions
// - Unkeyed protected writes are silently dropped
// - Control and lock share one key
// - Control at 0x00: window 7:4, period 3:0
// - Window codes 1..B select window mode
// - Codes 1..B give 8..8192 watchdog ticks
// - Period codes 1..B enable, zero and reserved codes disable
// - Window mode: period sets open window
// - Lock set makes control read-only
// - Outside debug mode, software may only set lock
// - Lock clears only in debug mode
// - Nonzero fuse period sets lock at boot
// - Busy set on control write during crossing
// - Busy clears when crossing completes
// - Busy flag is not key protected
// - Status at 0x04, lock bit7, busy bit0
// - Control reset value comes from fuse
// - Restart begins new period; expiry resets
// - Closed-window restart resets; armed after restart
//
`timescale 1ns/1ps
module wdu_core
   import wdu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic key_written,
   input wire logic instr_step,
   input wire logic restart_instr,
   input wire logic wdt_tick,
   input wire logic debug_mode,
   input wire logic [7:0] fuse_cfg,
   output logic sys_reset_req
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic boot_done_r;
   logic [7:0] ctrl_r;
   logic [7:0] cfg_act_r;
   logic lock_r;
   logic busy_r;
   logic [1:0] sync_cnt_r;
   logic restart_pend_r;
   logic sys_reset_r;
   logic [13:0] cnt_r;
   wdu_state_t state_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   logic setup;
   logic access;
   logic wr_ctrl;
   logic wr_stat;
   logic unlocked;
   logic ctrl_take;
   logic lock_set;
   logic lock_clr;
   logic [13:0] per_len;
   logic [13:0] win_len;
   logic timeout_hit;
   logic closed_hit;
   logic mapped;
   logic sync_done;

   ////////////////////////////////////////////////////////////////////
   // Period decode; reserved codes give zero, which means disabled

   function automatic logic [13:0] wdu_len(input logic [3:0] code);
      logic [3:0] sh;
      sh = code - WDU_CODE_MIN;
      if (code == WDU_CODE_OFF || code > WDU_CODE_MAX) begin
         wdu_len = 14'h0000;
      end else begin
         wdu_len = WDU_BASE_TICKS << sh;
      end
   endfunction

   assign per_len = wdu_len(cfg_act_r[WDU_PER_MSB:WDU_PER_LSB]);
   assign win_len = wdu_len(cfg_act_r[WDU_WIN_MSB:WDU_WIN_LSB]);

   ////////////////////////////////////////////////////////////////////
   // APB decode

   assign setup = psel && !penable;
   assign access = psel && penable && pce;
   assign mapped = (paddr == WDU_ADDR_CTRL) || (paddr == WDU_ADDR_STAT);
   assign wr_ctrl = access && pwrite && (paddr == WDU_ADDR_CTRL) && boot_done_r;
   assign wr_stat = access && pwrite && (paddr == WDU_ADDR_STAT) && boot_done_r;

   // Zero wait states: the answer is prepared during the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   ////////////////////////////////////////////////////////////////////
   // Timed unlock

   wdu_unlock u_unlock (
      .pclk(pclk),
      .presetn(presetn),
      .pce(pce),
      .key_written(key_written),
      .instr_step(instr_step),
      .consume(wr_ctrl || wr_stat),
      .unlocked(unlocked)
   );

   // Both the control word and the lock bit hang off the same key
   assign ctrl_take = wr_ctrl && unlocked && !lock_r;
   assign lock_set = wr_stat && unlocked && pwdata[WDU_LOCK_BIT];
   // Lock can be dropped only with the CPU halted
   assign lock_clr = wr_stat && unlocked && !pwdata[WDU_LOCK_BIT] && debug_mode;

   ////////////////////////////////////////////////////////////////////
   // Boot load from the fuse; the fuse is sampled after reset release,
   // never through the asynchronous reset itself

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_done_r <= 1'b0;
      end else if (pce) begin
         boot_done_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= WDU_CTRL_RST;
      end else if (pce) begin
         if (!boot_done_r) begin
            ctrl_r <= fuse_cfg;
         end else if (ctrl_take) begin
            ctrl_r <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Lock bit

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_r <= WDU_STAT_RST[WDU_LOCK_BIT];
      end else if (pce) begin
         if (!boot_done_r) begin
            lock_r <= (fuse_cfg[WDU_PER_MSB:WDU_PER_LSB] != WDU_CODE_OFF);
         end else if (lock_set) begin
            lock_r <= 1'b1;
         end else if (lock_clr) begin
            lock_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Crossing of the control word into the watchdog tick domain.
   // The boot value crosses too, so busy is also seen right after boot.
   // A write while busy restarts the crossing; software should not
   // rely on that.

   // Last tick of the crossing
   assign sync_done = busy_r && wdt_tick && sync_cnt_r == WDU_SYNC_TICKS - 2'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= WDU_STAT_RST[WDU_BUSY_BIT];
      end else if (pce) begin
         if (!boot_done_r || ctrl_take) begin
            busy_r <= 1'b1;
         end else if (sync_done) begin
            busy_r <= 1'b0;
         end
      end
   end

   // Tick count of the crossing in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_cnt_r <= 2'h0;
      end else if (pce) begin
         if (!boot_done_r || ctrl_take || sync_done) begin
            sync_cnt_r <= 2'h0;
         end else if (busy_r && wdt_tick) begin
            sync_cnt_r <= sync_cnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_act_r <= WDU_CTRL_RST;
      end else if (pce) begin
         if (sync_done && !ctrl_take) begin
            cfg_act_r <= ctrl_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Restart request, applied at the next watchdog tick.
   // A new request in the same cycle as a tick survives the clear.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         restart_pend_r <= 1'b0;
      end else if (pce) begin
         restart_pend_r <= restart_instr || (restart_pend_r && !wdt_tick);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Watchdog counter and window phase

   assign timeout_hit = wdt_tick && !restart_pend_r && !debug_mode
      && (state_r == WDU_NORMAL || state_r == WDU_OPEN)
      && per_len != 14'h0000 && cnt_r == per_len - 14'h0001;
   assign closed_hit = wdt_tick && restart_pend_r && !debug_mode
      && state_r == WDU_CLOSED && per_len != 14'h0000;

   // Window phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= WDU_OFF;
      end else if (pce) begin
         if (debug_mode) begin
            // Halted CPU: first period after exit is normal
            state_r <= (per_len == 14'h0000) ? WDU_OFF : WDU_NORMAL;
         end else if (per_len == 14'h0000) begin
            state_r <= WDU_OFF;
         end else if (wdt_tick) begin
            case (state_r)
               WDU_OFF: begin
                  // Freshly enabled: window not armed until first restart
                  state_r <= WDU_NORMAL;
               end
               WDU_NORMAL, WDU_OPEN: begin
                  if (restart_pend_r) begin
                     state_r <= (win_len != 14'h0000) ? WDU_CLOSED : WDU_NORMAL;
                  end
               end
               WDU_CLOSED: begin
                  if (win_len == 14'h0000) begin
                     state_r <= WDU_NORMAL;
                  end else if (cnt_r == win_len - 14'h0001) begin
                     state_r <= WDU_OPEN;
                  end
               end
               default: begin
                  state_r <= WDU_OFF;
               end
            endcase
         end
      end
   end

   // Tick counter of the current phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 14'h0000;
      end else if (pce) begin
         if (debug_mode || per_len == 14'h0000) begin
            // Halted CPU or disabled unit: count starts over
            cnt_r <= 14'h0000;
         end else if (wdt_tick) begin
            case (state_r)
               WDU_NORMAL, WDU_OPEN: begin
                  if (restart_pend_r || cnt_r == per_len - 14'h0001) begin
                     cnt_r <= 14'h0000;
                  end else begin
                     cnt_r <= cnt_r + 14'h0001;
                  end
               end
               WDU_CLOSED: begin
                  if (win_len == 14'h0000 || cnt_r == win_len - 14'h0001) begin
                     cnt_r <= 14'h0000;
                  end else begin
                     cnt_r <= cnt_r + 14'h0001;
                  end
               end
               default: begin
                  cnt_r <= 14'h0000;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // System reset request; held until the system reset clears it

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_r <= 1'b0;
      end else if (pce) begin
         if (timeout_hit || closed_hit) begin
            sys_reset_r <= 1'b1;
         end
      end
   end

   assign sys_reset_req = sys_reset_r;

   ////////////////////////////////////////////////////////////////////
   // Read data and error, captured in the setup cycle

   // Unmapped offsets answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_r <= 1'b0;
      end else if (pce && setup) begin
         pslverr_r <= !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (pce) begin
         if (setup) begin
            if (paddr == WDU_ADDR_CTRL) begin
               prdata_r <= {24'h00_0000, ctrl_r};
            end else if (paddr == WDU_ADDR_STAT) begin
               // Busy reads straight through; no key involved
               prdata_r <= {24'h00_0000, lock_r, 6'h00, busy_r};
            end else begin
               prdata_r <= 32'h0000_0000;
            end
         end
      end
   end

endmodule

// [tb/wdu_checker.sv]
`timescale 1ns/1ps
module wdu_checker
   import wdu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic key_written,
   input wire logic instr_step,
   input wire logic restart_instr,
   input wire logic wdt_tick,
   input wire logic debug_mode,
   input wire logic [7:0] fuse_cfg,
   input wire logic sys_reset_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire mapd = paddr == WDU_ADDR_CTRL || paddr == WDU_ADDR_STAT;
   //////////////////////////////
   err_unmapped_a: assert property (acc && !mapd |-> pslverr)
      else $error("no error on unmapped access");
   err_mapped_a: assert property (acc && mapd |-> !pslverr)
      else $error("error on mapped access");
   read_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   stat_resv_a: assert property (acc && !pwrite && paddr == WDU_ADDR_STAT
      |-> prdata[6:1] == 6'h00)
      else $error("status unused bits set");
   reset_sticky_a: assert property (sys_reset_req |=> sys_reset_req)
      else $error("reset request dropped");
   reset_tick_a: assert property ($rose(sys_reset_req) |-> $past(wdt_tick))
      else $error("reset request off tick");
   debug_quiet_a: assert property ($rose(sys_reset_req) |-> !$past(debug_mode))
      else $error("reset request in debug");
   boot_clean_a: assert property ($rose(presetn) |-> !sys_reset_req ##1 !sys_reset_req)
      else $error("reset request at boot");
   cover property (acc && !mapd);
   cover property ($rose(sys_reset_req));
   cover property (acc && pwrite && paddr == WDU_ADDR_STAT);
endmodule
bind wdu_core wdu_checker i_chk(.pclk(pclk), .presetn(presetn), .pce(pce),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_written(key_written),
   .instr_step(instr_step), .restart_instr(restart_instr), .wdt_tick(wdt_tick),
   .debug_mode(debug_mode), .fuse_cfg(fuse_cfg), .sys_reset_req(sys_reset_req));

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
   import wdu_pkg::*;
;
   logic pclk = 1'h0;
   logic presetn, pce, psel, penable, pwrite, pready, pslverr, sys_reset_req;
   logic key_written, instr_step, restart_instr, wdt_tick, debug_mode, rerr;
   logic [7:0] paddr, fuse_cfg;
   logic [31:0] pwdata, prdata, rdat;
   int n_fail = 0;
   int check_count = 0;
   localparam logic [7:0] CT = WDU_ADDR_CTRL;
   localparam logic [7:0] ST = WDU_ADDR_STAT;
   wdu_core i_wdu_core(.pclk(pclk), .presetn(presetn), .pce(pce), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .key_written(key_written),
      .instr_step(instr_step), .restart_instr(restart_instr), .wdt_tick(wdt_tick),
      .debug_mode(debug_mode), .fuse_cfg(fuse_cfg), .sys_reset_req(sys_reset_req));
   always #2.5 pclk = ~pclk;
   //////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      // Only the watchdog process ends a wait that never completes
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Gap cycle keeps strobes from being assigned twice in one step
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'h0, a, 8'h00);
      chk(rdat, {24'h000000, e});
   endtask
   task automatic pulse(input int s, input int n);
      repeat (n) begin
         if (s == 0) key_written <= 1'h1;
         if (s == 1) instr_step <= 1'h1;
         if (s == 2) restart_instr <= 1'h1;
         if (s == 3) wdt_tick <= 1'h1;
         @(posedge pclk);
         {key_written, instr_step, restart_instr, wdt_tick} <= 4'h0;
         @(posedge pclk);
      end
   endtask
   task automatic rst(input logic [7:0] f);
      fuse_cfg <= f;
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask
   //////////////////////////////
   task automatic t_keyed();
      rd(ST, 8'h01);
      pulse(3, 2);
      rd(ST, 8'h00);
      pulse(0, 1);
      apb(1'h1, CT, 8'h30);
      rd(ST, 8'h01);
      pulse(3, 1);
      rd(ST, 8'h01);
      pulse(3, 1);
      rd(ST, 8'h00);
      rd(CT, 8'h30);
      apb(1'h1, CT, 8'h55);
      rd(CT, 8'h30);
      rd(ST, 8'h00);
      $display("keyed test done");
   endtask
   task automatic t_expire();
      pulse(0, 1);
      pulse(1, 4);
      apb(1'h1, CT, 8'h77);
      rd(CT, 8'h30);
      pulse(0, 1);
      pulse(1, 3);
      apb(1'h1, CT, 8'h40);
      rd(CT, 8'h40);
      pulse(3, 2);
      $display("expire test done");
   endtask
   task automatic t_lock();
      pulse(0, 1);
      apb(1'h1, ST, 8'h80);
      rd(ST, 8'h80);
      pulse(0, 1);
      apb(1'h1, CT, 8'h50);
      rd(CT, 8'h40);
      pulse(0, 1);
      apb(1'h1, ST, 8'h00);
      rd(ST, 8'h80);
      debug_mode <= 1'h1;
      pulse(0, 1);
      apb(1'h1, ST, 8'h00);
      rd(ST, 8'h00);
      debug_mode <= 1'h0;
      apb(1'h1, ST, 8'h80);
      rd(ST, 8'h00);
      apb(1'h0, 8'h08, 8'h00);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      $display("lock test done");
   endtask
   task automatic t_timeout();
      // A key seen while the clock enable is low must not open the bus
      pce <= 1'h0;
      pulse(0, 1);
      pce <= 1'h1;
      apb(1'h1, CT, 8'h0C);
      rd(CT, 8'h40);
      pulse(0, 1);
      apb(1'h1, CT, 8'h0C);
      pulse(3, 20);
      chk({31'h0, sys_reset_req}, 32'h0);
      pulse(0, 1);
      apb(1'h1, CT, 8'h01);
      pulse(3, 7);
      pulse(2, 1);
      pulse(3, 6);
      chk({31'h0, sys_reset_req}, 32'h0);
      pulse(3, 4);
      chk({31'h0, sys_reset_req}, 32'h1);
      $display("timeout test done");
   endtask
   task automatic t_window();
      rst(8'h12);
      rd(ST, 8'h81);
      rd(CT, 8'h12);
      pulse(3, 3);
      pulse(2, 1);
      pulse(3, 2);
      chk({31'h0, sys_reset_req}, 32'h0);
      pulse(2, 1);
      pulse(3, 3);
      chk({31'h0, sys_reset_req}, 32'h1);
      $display("window test done");
   endtask
   //////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, debug_mode} = 5'h00;
      {key_written, instr_step, restart_instr, wdt_tick} = 4'h0;
      pce = 1'h1;
      paddr = 8'h00;
      pwdata = 32'h0;
      fuse_cfg = 8'h00;
      rst(8'h00);
      t_keyed();
      t_expire();
      t_lock();
      t_timeout();
      t_window();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end
endmodule
